//--- rtl/psr_pkg.sv
// Constants shared by the transceiver vendor register bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package psr_pkg;
  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [4:0] REG_CFG2 = 5'h11;
  localparam logic [4:0] REG_STAT = 5'h12;
  localparam logic [4:0] REG_MASK = 5'h13;
  localparam logic [4:0] REG_FACT = 5'h14;
  // --------------------------------------------------------------------------
  // Fields and reset values
  // --------------------------------------------------------------------------
  localparam int CFG2_RW_W = 6;
  localparam int BIT_APOL_OFF = 5;
  localparam int BIT_GUARD_OFF = 4;
  localparam int BIT_MULTI_EN = 3;
  localparam int BIT_IRQ_LINE = 2;
  localparam logic [7:0] CFG2_HI_FIXED = 8'hff;
  localparam logic [1:0] CFG2_MID_FIXED = 2'h0;
  localparam logic [5:0] CFG2_RST = 6'h00;
  localparam logic [15:0] MASK_RST = 16'hffc0;
  localparam logic [15:0] FACT_RST = 16'h00a0;
  localparam int LATCH_N = 7;
  localparam int EVT_N = 9;
  localparam int MASK_SUM = 15;
  localparam int MASK_EVT_LO = 6;
  localparam logic SPD_RST = 1'b1;
  localparam logic DPX_RST = 1'b0;
  localparam logic [5:0] STAT_LO_FIXED = 6'h00;
  localparam logic [15:0] UNMAPPED_VAL = 16'h0000;
  // --------------------------------------------------------------------------
  // Management frame
  // --------------------------------------------------------------------------
  localparam logic [1:0] OP_RD = 2'b10;
  localparam logic [1:0] OP_WR = 2'b01;
  localparam logic [5:0] PRE_LEN = 6'd32;
  localparam logic [3:0] OP_LAST = 4'd1;
  localparam logic [3:0] ADDR_LAST = 4'd9;
  localparam logic [3:0] TA_LAST = 4'd1;
  localparam logic [3:0] DATA_LAST = 4'd15;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int IRQ_PULSE_NS = 200;
  localparam logic [3:0] IRQ_PULSE_CYC =
    4'((IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_START = 3'b001,
    FR_OPC = 3'b010,
    FR_ADDR = 3'b011,
    FR_TURN = 3'b100,
    FR_DATA = 3'b101
  } psr_frame_t;
endpackage

//--- rtl/psr_pin_sync.sv
// Three flop pin synchroniser with agreement filter
`timescale 1ns/1ns
module psr_pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_LVL = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinLvl
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= RST_LVL;
      s2_reg <= RST_LVL;
      s3_reg <= RST_LVL;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pinLvl[i] <= RST_LVL[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          pinLvl[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

//--- rtl/psr_mdio_frame.sv
// Management frame engine and idle line interrupt pulse
`timescale 1ns/1ns
module psr_mdio_frame import psr_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdcLvl,
  input wire logic mdioLvl,
  input wire logic multiEn,
  input wire logic irqReq,
  input wire logic [15:0] rdData,
  output logic rdReq,
  output logic wrReq,
  output logic [4:0] regAddr,
  output logic [15:0] wrData,
  output logic mdioOut,
  output logic mdioOe
);
  psr_frame_t state_reg;
  logic mdcPrev_reg;
  logic [5:0] preCnt_reg;
  logic [3:0] bitCnt_reg;
  logic [11:0] hdr_reg;
  logic [15:0] dataSh_reg;
  logic ours_reg;
  logic rdOe_reg;
  logic rdBit_reg;
  logic irqPend_reg;
  logic [3:0] pulseCnt_reg;
  logic rise;
  logic pulseStart;

  assign rise = mdcLvl & ~mdcPrev_reg;
  assign pulseStart = irqPend_reg && (pulseCnt_reg == 4'h0) && (state_reg == FR_IDLE);

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= FR_IDLE;
      mdcPrev_reg <= 1'b1;
      preCnt_reg <= 6'h00;
      bitCnt_reg <= 4'h0;
      hdr_reg <= 12'h000;
      dataSh_reg <= 16'h0000;
      ours_reg <= 1'b0;
      rdOe_reg <= 1'b0;
      rdBit_reg <= 1'b1;
      rdReq <= 1'b0;
      wrReq <= 1'b0;
      regAddr <= 5'h00;
      wrData <= 16'h0000;
    end else begin
      mdcPrev_reg <= mdcLvl;
      rdReq <= 1'b0;
      wrReq <= 1'b0;
      if (rise) begin
        case (state_reg)
          FR_IDLE: begin
            if (mdioLvl) begin
              if (preCnt_reg != PRE_LEN) begin
                preCnt_reg <= preCnt_reg + 6'h01;
              end
            end else if (preCnt_reg == PRE_LEN || multiEn) begin
              state_reg <= FR_START;
            end else begin
              preCnt_reg <= 6'h00;
            end
          end
          FR_START: begin
            bitCnt_reg <= 4'h0;
            state_reg <= mdioLvl ? FR_OPC : FR_IDLE;
            preCnt_reg <= 6'h00;
          end
          FR_OPC, FR_ADDR: begin
            hdr_reg <= {hdr_reg[10:0], mdioLvl};
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (state_reg == FR_OPC && bitCnt_reg == OP_LAST) begin
              state_reg <= FR_ADDR;
              bitCnt_reg <= 4'h0;
            end
            if (state_reg == FR_ADDR && bitCnt_reg == ADDR_LAST) begin
              state_reg <= FR_TURN;
              bitCnt_reg <= 4'h0;
              regAddr <= {hdr_reg[3:0], mdioLvl};
              ours_reg <= (hdr_reg[8:4] == PHY_ADDR);
              rdReq <= (hdr_reg[8:4] == PHY_ADDR) && (hdr_reg[10:9] == OP_RD);
            end
          end
          FR_TURN: begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (ours_reg && hdr_reg[11:10] == OP_RD) begin
              rdOe_reg <= 1'b1;
              rdBit_reg <= (bitCnt_reg == TA_LAST) ? rdData[15] : 1'b0;
              dataSh_reg <= rdData;
            end
            if (bitCnt_reg == TA_LAST) begin
              state_reg <= FR_DATA;
              bitCnt_reg <= 4'h0;
            end
          end
          FR_DATA: begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            dataSh_reg <= {dataSh_reg[14:0], mdioLvl};
            rdBit_reg <= rdOe_reg ? dataSh_reg[14] : 1'b1;
            if (bitCnt_reg == DATA_LAST) begin
              state_reg <= FR_IDLE;
              rdOe_reg <= 1'b0;
              rdBit_reg <= 1'b1;
              wrData <= {dataSh_reg[14:0], mdioLvl};
              wrReq <= ours_reg && (hdr_reg[11:10] == OP_WR);
            end
          end
          default: begin
            state_reg <= FR_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt pulse on the idle line
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqPend_reg <= 1'b0;
      pulseCnt_reg <= 4'h0;
    end else begin
      irqPend_reg <= irqReq | (irqPend_reg & ~pulseStart);
      if (pulseStart) begin
        pulseCnt_reg <= IRQ_PULSE_CYC;
      end else if (pulseCnt_reg != 4'h0) begin
        pulseCnt_reg <= pulseCnt_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mdioOe <= 1'b0;
      mdioOut <= 1'b1;
    end else begin
      mdioOe <= rdOe_reg | (pulseCnt_reg != 4'h0);
      mdioOut <= (pulseCnt_reg != 4'h0) ? 1'b0 : rdBit_reg;
    end
  end
endmodule

//--- rtl/psr_status_regs.sv
// Vendor configuration, latched status and mask registers behind the management port
`timescale 1ns/1ns
module psr_status_regs import psr_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic linkUp,
  input wire logic descrUnlocked,
  input wire logic badCodeGroup,
  input wire logic missingStartDelim,
  input wire logic missingEndDelim,
  input wire logic polarityReversed,
  input wire logic overlongTx,
  input wire logic speedIsFast,
  input wire logic fullDuplex,
  output logic autoPolarityOff,
  output logic longTxGuardOff,
  output logic multiRegisterAccessEn,
  output logic irqOnMgmtLine,
  output logic irqPending
);
  logic [1:0] pinLvl;
  logic rdReq;
  logic wrReq;
  logic [4:0] regAddr;
  logic [15:0] wrData;
  logic [15:0] rdData_reg;
  logic [5:0] cfg2_reg;
  logic [15:0] mask_reg;
  logic [15:0] fact_reg;
  logic [LATCH_N-1:0] latch_reg;
  logic [LATCH_N-1:0] latch_next;
  logic [LATCH_N-1:0] cond;
  logic spd_reg;
  logic dpx_reg;
  logic sum_reg;
  logic sum_next;
  logic irq_next;
  logic irqReq_reg;
  logic statRead;
  logic [EVT_N-1:0] chg;
  logic [EVT_N-1:0] unmasked;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic hits(input logic [4:0] a, input logic [4:0] r);
    hits = (a == r);
  endfunction

  // --------------------------------------------------------------------------
  // Pins and frame engine
  // --------------------------------------------------------------------------
  psr_pin_sync #(.W(2), .RST_LVL(2'b11)) uSync (
    .clock(clock),
    .rst(rst),
    .pinIn({mdc, mdioIn}),
    .pinLvl(pinLvl)
  );

  psr_mdio_frame #(.PHY_ADDR(PHY_ADDR)) uFrame (
    .clock(clock),
    .rst(rst),
    .mdcLvl(pinLvl[1]),
    .mdioLvl(pinLvl[0]),
    .multiEn(cfg2_reg[BIT_MULTI_EN]),
    .irqReq(irqReq_reg),
    .rdData(rdData_reg),
    .rdReq(rdReq),
    .wrReq(wrReq),
    .regAddr(regAddr),
    .wrData(wrData),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe)
  );

  // --------------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg2_reg <= CFG2_RST;
      mask_reg <= MASK_RST;
      fact_reg <= FACT_RST;
    end else if (wrReq) begin
      if (hits(regAddr, REG_CFG2)) begin
        cfg2_reg <= wrData[CFG2_RW_W-1:0];
      end
      if (hits(regAddr, REG_MASK)) begin
        mask_reg <= wrData;
      end
      if (hits(regAddr, REG_FACT)) begin
        fact_reg <= wrData;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autoPolarityOff <= 1'b0;
      longTxGuardOff <= 1'b0;
      multiRegisterAccessEn <= 1'b0;
      irqOnMgmtLine <= 1'b0;
    end else begin
      autoPolarityOff <= cfg2_reg[BIT_APOL_OFF];
      longTxGuardOff <= cfg2_reg[BIT_GUARD_OFF];
      multiRegisterAccessEn <= cfg2_reg[BIT_MULTI_EN];
      irqOnMgmtLine <= cfg2_reg[BIT_IRQ_LINE];
    end
  end

  // --------------------------------------------------------------------------
  // Latched status and change tracking
  // --------------------------------------------------------------------------
  assign statRead = rdReq && hits(regAddr, REG_STAT);
  assign cond = {
    ~linkUp,
    descrUnlocked,
    badCodeGroup,
    missingStartDelim,
    missingEndDelim,
    polarityReversed,
    overlongTx
  };
  assign latch_next = (statRead ? {LATCH_N{1'b0}} : latch_reg) | cond;
  assign chg = {cond & ~latch_reg, spd_reg ^ speedIsFast, dpx_reg ^ fullDuplex};
  assign unmasked = chg & ~mask_reg[MASK_SUM-1:MASK_EVT_LO];
  assign sum_next = (statRead ? 1'b0 : sum_reg) | (|chg);
  assign irq_next = (statRead ? 1'b0 : irqPending) | ((|unmasked) & ~mask_reg[MASK_SUM]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_reg <= {LATCH_N{1'b0}};
      spd_reg <= SPD_RST;
      dpx_reg <= DPX_RST;
      sum_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      spd_reg <= speedIsFast;
      dpx_reg <= fullDuplex;
      sum_reg <= sum_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqPending <= 1'b0;
      irqReq_reg <= 1'b0;
    end else begin
      irqPending <= irq_next;
      irqReq_reg <= (|unmasked) & ~mask_reg[MASK_SUM] & cfg2_reg[BIT_IRQ_LINE];
    end
  end

  // --------------------------------------------------------------------------
  // Read snapshot, taken before the read clears the latches
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_reg <= UNMAPPED_VAL;
    end else if (rdReq) begin
      if (hits(regAddr, REG_CFG2)) begin
        rdData_reg <= {CFG2_HI_FIXED, CFG2_MID_FIXED, cfg2_reg};
      end else if (hits(regAddr, REG_STAT)) begin
        rdData_reg <= {sum_reg, latch_reg, spd_reg, dpx_reg, STAT_LO_FIXED};
      end else if (hits(regAddr, REG_MASK)) begin
        rdData_reg <= mask_reg;
      end else if (hits(regAddr, REG_FACT)) begin
        rdData_reg <= fact_reg;
      end else begin
        rdData_reg <= UNMAPPED_VAL;
      end
    end
  end
endmodule

//--- sim/psr_status_regs_asserts.sv
// Port-level checker for the vendor register bank
`timescale 1ns/1ns
module psr_status_regs_asserts #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic linkUp,
  input wire logic descrUnlocked,
  input wire logic badCodeGroup,
  input wire logic missingStartDelim,
  input wire logic missingEndDelim,
  input wire logic polarityReversed,
  input wire logic overlongTx,
  input wire logic speedIsFast,
  input wire logic fullDuplex,
  input wire logic autoPolarityOff,
  input wire logic longTxGuardOff,
  input wire logic multiRegisterAccessEn,
  input wire logic irqOnMgmtLine,
  input wire logic irqPending
);
  logic mdcD;
  logic spdD;
  logic dpxD;
  logic [3:0] since;
  logic [2:0] evtHist;
  logic evtNow;
  logic [3:0] ctrl;
  assign ctrl = {autoPolarityOff, longTxGuardOff, multiRegisterAccessEn, irqOnMgmtLine};
  assign evtNow = !linkUp | descrUnlocked | badCodeGroup | missingStartDelim
    | missingEndDelim | polarityReversed | overlongTx | (speedIsFast ^ spdD)
    | (fullDuplex ^ dpxD);
  // Clocks since the last raw management clock rise, and recent events
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mdcD <= 1'b1;
      spdD <= 1'b1;
      dpxD <= 1'b0;
      since <= 4'hf;
      evtHist <= 3'h0;
    end else begin
      mdcD <= mdc;
      spdD <= speedIsFast;
      dpxD <= fullDuplex;
      evtHist <= {evtHist[1:0], evtNow};
      if (mdc && !mdcD) begin
        since <= 4'h0;
      end else if (since != 4'hf) begin
        since <= since + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_idle_high: assert property (!mdioOe |-> mdioOut)
    else $error("data line not high while released");
  a_reset_quiet: assert property ($fell(rst) |-> !mdioOe && !irqPending)
    else $error("activity right after reset");
  a_no_pulse_off: assert property ($rose(mdioOe) && !irqOnMgmtLine
    |-> since inside {[2:6]}) else $error("drive without clock edge");
  a_pulse_cfg: assert property ($rose(mdioOe) && since > 4'h6 |-> irqOnMgmtLine)
    else $error("idle pulse while disabled");
  a_pulse_len: assert property ($rose(mdioOe) && since > 4'h6
    |-> (mdioOe && !mdioOut) [*5] ##1 !mdioOe) else $error("idle pulse length wrong");
  a_bit_timing: assert property (mdioOe && $past(mdioOe) && $changed(mdioOut)
    |-> since inside {[2:9]}) else $error("read bit changed off edge");
  a_ctrl_write: assert property ($changed(ctrl) |-> since inside {[2:10]})
    else $error("control output changed without write");
  a_irq_cause: assert property ($rose(irqPending) |-> evtHist != 3'h0)
    else $error("pending raised without event");
  a_irq_clear: assert property ($fell(irqPending) |-> since inside {[2:12]})
    else $error("pending cleared without read");
  c_pulse: cover property ($rose(mdioOe) && since > 4'h6);
  c_irq: cover property ($rose(irqPending));
  c_ctrl: cover property ($changed(ctrl));
endmodule

bind psr_status_regs psr_status_regs_asserts #(.PHY_ADDR(PHY_ADDR)) psr_status_regs_asserts_i (
  .clock(clock), .rst(rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
  .mdioOe(mdioOe), .linkUp(linkUp), .descrUnlocked(descrUnlocked),
  .badCodeGroup(badCodeGroup), .missingStartDelim(missingStartDelim),
  .missingEndDelim(missingEndDelim), .polarityReversed(polarityReversed),
  .overlongTx(overlongTx), .speedIsFast(speedIsFast), .fullDuplex(fullDuplex),
  .autoPolarityOff(autoPolarityOff), .longTxGuardOff(longTxGuardOff),
  .multiRegisterAccessEn(multiRegisterAccessEn), .irqOnMgmtLine(irqOnMgmtLine),
  .irqPending(irqPending)
);

//--- sim/psr_mgmt_station.sv
// Management station model framing requests on the clock and data pins
`timescale 1ns/1ns
module psr_mgmt_station import psr_pkg::*; (
  input wire logic clock,
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic drv;
  logic bitOut;
  // Line is pulled up, so a released line reads 1
  assign mdioIn = (drv ? bitOut : 1'b1) & (mdioOe ? mdioOut : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    bitOut = 1'b1;
  end
  // Data set while the clock is low, sampled just before it rises
  task automatic put(input logic en, input logic b, output logic s);
    drv = en;
    bitOut = b;
    repeat (6) @(negedge clock);
    s = mdioIn;
    mdc = 1'b1;
    repeat (6) @(negedge clock);
    mdc = 1'b0;
  endtask
  // Whole frame, MSB first; read frames release the line from turnaround on
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic w;
    hdr = {2'b01, op, phy, ra};
    w = (op == OP_WR);
    if (pre) begin
      repeat (32) put(1'b1, 1'b1, s);
    end
    for (int k = 13; k >= 0; k--) begin
      put(1'b1, hdr[k], s);
    end
    put(w, 1'b1, s);
    put(w, 1'b0, s);
    for (int k = 15; k >= 0; k--) begin
      put(w, wd[k], s);
      rd[k] = s;
    end
    drv = 1'b0;
    @(negedge clock);
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the vendor register bank
`timescale 1ns/1ns
module tb_top import psr_pkg::*;;
  localparam logic [4:0] PHY = 5'h03;
  logic clock;
  logic rst;
  logic mdc;
  logic mdioIn;
  logic mdioOut;
  logic mdioOe;
  logic [6:0] cause;
  logic speedIsFast;
  logic fullDuplex;
  logic [3:0] ctrl;
  logic irqPending;
  logic [15:0] d;
  logic pend;
  logic pulsed;
  logic [3:0] v;
  int nErrors;
  int checksDone;
  int i;
  int j;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  psr_status_regs #(.PHY_ADDR(PHY)) psr_status_regs_i (
    .clock(clock), .rst(rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .linkUp(!cause[6]), .descrUnlocked(cause[5]),
    .badCodeGroup(cause[4]), .missingStartDelim(cause[3]), .missingEndDelim(cause[2]),
    .polarityReversed(cause[1]), .overlongTx(cause[0]), .speedIsFast(speedIsFast),
    .fullDuplex(fullDuplex), .autoPolarityOff(ctrl[3]), .longTxGuardOff(ctrl[2]),
    .multiRegisterAccessEn(ctrl[1]), .irqOnMgmtLine(ctrl[0]), .irqPending(irqPending)
  );
  psr_mgmt_station psr_mgmt_station_i (
    .clock(clock), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe)
  );
  function automatic logic [15:0] stat(input int k);
    return 16'h8080 | (16'h0100 << k);
  endfunction
  function automatic logic [15:0] cfgv(input logic [3:0] b);
    return {8'hff, 2'b00, b, 2'b00};
  endfunction
  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    cmp16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    logic [15:0] x;
    psr_mgmt_station_i.frame(1'b1, OP_WR, PHY, a, w, x);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] x;
    psr_mgmt_station_i.frame(1'b1, OP_RD, PHY, a, 16'h0000, x);
    cmp16(nm, e, x);
  endtask
  task automatic hit(input int k);
    cause[k] = 1'b1;
    @(negedge clock);
    cause[k] = 1'b0;
  endtask
  task automatic watch(output logic p, output logic q);
    p = 1'b0;
    q = 1'b0;
    repeat (40) begin
      @(negedge clock);
      if (irqPending === 1'b1) p = 1'b1;
      if (mdioOe === 1'b1 && mdioOut === 1'b0) q = 1'b1;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    cause = 7'h00;
    speedIsFast = 1'b1;
    fullDuplex = 1'b0;
    nErrors = 0;
    checksDone = 0;
    void'($urandom(32'h613c));
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    cmp16("ctrl", 16'h0000, {12'h000, ctrl});
    rdc("cfg2", REG_CFG2, 16'hff00);
    rdc("status", REG_STAT, 16'h0080);
    rdc("mask", REG_MASK, 16'hffc0);
    rdc("factory", REG_FACT, 16'h00a0);
    rdc("unmapped", 5'h15, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom);
      wr(REG_CFG2, cfgv(v));
      rdc("cfg2", REG_CFG2, cfgv(v));
      cmp16("ctrl", {12'h000, v}, {12'h000, ctrl});
    end
    wr(REG_CFG2, 16'hff00);
    $display("test config done");
    for (i = 0; i < 7; i++) begin
      hit(i);
      rdc("status", REG_STAT, stat(i));
      rdc("status", REG_STAT, 16'h0080);
    end
    cmp1("irq", 1'b0, irqPending);
    $display("test latch done");
    i = $urandom_range(6, 0);
    j = (i + 1) % 7;
    wr(REG_MASK, 16'h7fc0 & ~(16'h0100 << i));
    hit(j);
    watch(pend, pulsed);
    cmp1("irq", 1'b0, pend);
    hit(i);
    watch(pend, pulsed);
    cmp1("irq", 1'b1, pend);
    rdc("status", REG_STAT, stat(i) | stat(j));
    cmp1("irq", 1'b0, irqPending);
    wr(REG_CFG2, 16'hff04);
    hit(i);
    watch(pend, pulsed);
    cmp1("pulse", 1'b1, pulsed);
    rdc("status", REG_STAT, stat(i));
    wr(REG_CFG2, 16'hff00);
    hit(i);
    watch(pend, pulsed);
    cmp1("pulse", 1'b0, pulsed);
    rdc("status", REG_STAT, stat(i));
    wr(REG_MASK, 16'hffc0);
    $display("test interrupt done");
    psr_mgmt_station_i.frame(1'b1, OP_WR, PHY ^ 5'h01, REG_MASK, 16'h0000, d);
    psr_mgmt_station_i.frame(1'b1, OP_RD, PHY ^ 5'h01, REG_MASK, 16'h0000, d);
    cmp16("foreign", 16'hffff, d);
    psr_mgmt_station_i.frame(1'b0, OP_WR, PHY, REG_MASK, 16'h0000, d);
    rdc("mask", REG_MASK, 16'hffc0);
    wr(REG_CFG2, 16'hff08);
    psr_mgmt_station_i.frame(1'b0, OP_WR, PHY, REG_MASK, 16'h7fc0, d);
    psr_mgmt_station_i.frame(1'b0, OP_RD, PHY, REG_MASK, 16'h0000, d);
    cmp16("mask", 16'h7fc0, d);
    wr(REG_CFG2, 16'hff00);
    wr(REG_MASK, 16'hffc0);
    $display("test multi access done");
    speedIsFast = 1'b0;
    fullDuplex = 1'b1;
    rdc("status", REG_STAT, 16'h8040);
    speedIsFast = 1'b1;
    fullDuplex = 1'b0;
    rdc("status", REG_STAT, 16'h8080);
    $display("test speed done");
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    nErrors++;
    stop_test();
  end
endmodule
